// >>> nvac_chk_assertions.sv
/* Port checker for nvac_ctrl.
   Assumes the single clk domain and async rst. */
`include "nvac_defines.vh"
module nvac_chk (
	input wire clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_rdata,
	input wire low_power_req,
	input wire stack_full,
	input wire irq_ack,
	input wire irq_request,
	input wire nv_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence go_taken;
		$past(sfr_wr) && $past(sfr_addr) == `NVAC_ADDR_IAP;
	endsequence
	reset_clear_a: assert property ($fell(rst) |-> !nv_busy && !irq_request && !sfr_rdata)
		else $error("state not clear after reset");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (sfr_rd && sfr_addr == 8'hff |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	busy_cause_a: assert property ($rose(nv_busy) |-> go_taken)
		else $error("busy without a control write");
	irq_gate_a: assert property ($rose(irq_request) |-> !$past(stack_full))
		else $error("request while stack full");
	ack_clear_a: assert property (irq_ack && !$fell(nv_busy) |-> ##[1:2] !irq_request)
		else $error("request kept after service");
	sleep_abort_a: assert property (low_power_req && nv_busy |-> ##[1:2] !nv_busy)
		else $error("access not aborted by low power");
endmodule // nvac_chk
bind nvac_ctrl nvac_chk nvac_chk_i (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .low_power_req(low_power_req),
	.stack_full(stack_full), .irq_ack(irq_ack), .irq_request(irq_request), .nv_busy(nv_busy));

// >>> nvac_ctrl.v
/*
 Data EEPROM access controller: SFR port for index, value, pointer pair,
 indirect access port and interrupt control; read and self-timed write
 sequencing; write-done request. Assumes the CPU drives the SFR port on clk
 and that slow_clk comes from the free-running low speed oscillator.
*/
`include "nvac_defines.vh"

module nvac_ctrl #(
	parameter [7:0] WRITE_SLOW_EDGES = `NVAC_WRITE_SLOW_EDGES
) (
	input wire clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	output reg [7:0] sfr_rdata,
	input wire slow_clk,
	input wire low_power_req,
	input wire stack_full,
	input wire irq_ack,
	output reg irq_request,
	output reg nv_busy
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_READ = 2'h1;
	localparam [1:0] ST_WRITE = 2'h2;

	reg [7:0] nv_array [0:31];
	reg [4:0] cell_index_reg;
	reg [7:0] cell_value_reg;
	reg [7:0] pointer_low_byte;
	reg [7:0] pointer_high_byte;
	reg program_permit;
	reg program_cycle_go;
	reg fetch_permit;
	reg fetch_go;
	reg global_irq_enable;
	reg nv_done_irq_enable;
	reg nv_done_flag;
	reg [1:0] state;
	reg [1:0] read_cnt;
	reg [7:0] slow_cnt;
	reg slow_sync1;
	reg slow_sync2;
	reg slow_sync3;
	reg store_now;

	wire slow_edge;
	wire read_done;
	wire ctrl_wr;
	wire write_end;
	wire [7:0] ctrl_view;

	// Control register visible only through the port at 40H of sector 1
	function ctrl_hit;
		input [7:0] addr;
		input [7:0] lo;
		input [7:0] hi;
		begin
			ctrl_hit = (addr == `NVAC_ADDR_IAP) && (lo == `NVAC_CTRL_LOW) &&
				(hi == `NVAC_CTRL_SECTOR);
		end
	endfunction

	assign ctrl_wr = sfr_wr && ctrl_hit(sfr_addr, pointer_low_byte, pointer_high_byte);
	assign ctrl_view = {4'h0, program_permit, program_cycle_go, fetch_permit, fetch_go};

	// Slow timer passes two flops before the edge detector sees it
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_sync1 <= 1'b0;
			slow_sync2 <= 1'b0;
			slow_sync3 <= 1'b0;
		end else begin
			slow_sync1 <= slow_clk;
			slow_sync2 <= slow_sync1;
			slow_sync3 <= slow_sync2;
		end
	end

	assign slow_edge = slow_sync2 & ~slow_sync3;
	// Last clock of a read; the byte is taken here
	assign read_done = (state == ST_READ) && (read_cnt == `NVAC_READ_CYCLES - 2'h1);
	// Duration set by slow edges, so write length does not track clk
	assign write_end = (state == ST_WRITE) && slow_edge &&
		(slow_cnt == WRITE_SLOW_EDGES - 8'h01);

	// Sector 0 registers and the pointer pair
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cell_index_reg <= 5'h00;
			pointer_low_byte <= `NVAC_RESET_BYTE;
			pointer_high_byte <= `NVAC_RESET_BYTE;
		end else if (sfr_wr) begin
			if (sfr_addr == `NVAC_ADDR_INDEX) begin
				cell_index_reg <= sfr_wdata[4:0];
			end else if (sfr_addr == `NVAC_ADDR_PTR_LO) begin
				pointer_low_byte <= sfr_wdata;
			end else if (sfr_addr == `NVAC_ADDR_PTR_HI) begin
				pointer_high_byte <= sfr_wdata;
			end
		end
	end

	// Value register: software writes, read cycles load it
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cell_value_reg <= `NVAC_RESET_BYTE;
		end else if (read_done && !low_power_req) begin
			// A low power request in the last clock loses the byte
			cell_value_reg <= nv_array[cell_index_reg];
		end else if (sfr_wr && sfr_addr == `NVAC_ADDR_VALUE) begin
			cell_value_reg <= sfr_wdata;
		end
	end

	// Sequencer and control bits
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			program_permit <= 1'b0;
			program_cycle_go <= 1'b0;
			fetch_permit <= 1'b0;
			fetch_go <= 1'b0;
			read_cnt <= 2'h0;
			slow_cnt <= 8'h00;
			store_now <= 1'b0;
			nv_busy <= 1'b0;
		end else begin
			store_now <= 1'b0;
			if (ctrl_wr) begin
				program_permit <= sfr_wdata[`NVAC_BIT_PROG_PERMIT];
				fetch_permit <= sfr_wdata[`NVAC_BIT_FETCH_PERMIT];
			end
			if (state != ST_IDLE && low_power_req) begin
				// Entering idle or sleep aborts; nothing is stored
				state <= ST_IDLE;
				program_cycle_go <= 1'b0;
				fetch_go <= 1'b0;
				nv_busy <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					read_cnt <= 2'h0;
					slow_cnt <= 8'h00;
					// Old permit value gates the go bit, so one write cannot do both
					if (ctrl_wr && sfr_wdata[`NVAC_BIT_PROG_GO] && program_permit) begin
						program_cycle_go <= 1'b1;
						state <= ST_WRITE;
						nv_busy <= 1'b1;
					end else if (ctrl_wr && sfr_wdata[`NVAC_BIT_FETCH_GO] &&
						fetch_permit) begin
						// Write wins if software breaks the one-go-bit habit
						fetch_go <= 1'b1;
						state <= ST_READ;
						nv_busy <= 1'b1;
					end
				end
				ST_READ: begin
					read_cnt <= read_cnt + 2'h1;
					if (read_cnt == `NVAC_READ_CYCLES - 2'h1) begin
						fetch_go <= 1'b0;
						state <= ST_IDLE;
						nv_busy <= 1'b0;
					end
				end
				ST_WRITE: begin
					if (slow_edge) begin
						slow_cnt <= slow_cnt + 8'h01;
					end
					if (write_end) begin
						program_cycle_go <= 1'b0;
						store_now <= 1'b1;
						state <= ST_IDLE;
						nv_busy <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// Array has no reset: its contents model retained data
	always @(posedge clk) begin
		if (store_now) begin
			nv_array[cell_index_reg] <= cell_value_reg;
		end
	end

	// Interrupt control and the write-done flag; the write-end set beats a clear
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			global_irq_enable <= 1'b0;
			nv_done_irq_enable <= 1'b0;
			nv_done_flag <= 1'b0;
			irq_request <= 1'b0;
		end else begin
			if (sfr_wr && sfr_addr == `NVAC_ADDR_IRQCTL) begin
				global_irq_enable <= sfr_wdata[`NVAC_BIT_GIE];
				nv_done_irq_enable <= sfr_wdata[`NVAC_BIT_DONE_EN];
			end
			if (store_now) begin
				nv_done_flag <= 1'b1;
			end else if (irq_ack) begin
				nv_done_flag <= 1'b0;
			end else if (sfr_wr && sfr_addr == `NVAC_ADDR_IRQCTL) begin
				nv_done_flag <= sfr_wdata[`NVAC_BIT_DONE_FLAG];
			end
			irq_request <= nv_done_flag && nv_done_irq_enable && global_irq_enable &&
				!stack_full && !irq_ack;
		end
	end

	// Registered read data; unmapped addresses read zero
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			if (ctrl_hit(sfr_addr, pointer_low_byte, pointer_high_byte)) begin
				sfr_rdata <= ctrl_view;
			end else if (sfr_addr == `NVAC_ADDR_INDEX) begin
				sfr_rdata <= {3'h0, cell_index_reg};
			end else if (sfr_addr == `NVAC_ADDR_VALUE) begin
				sfr_rdata <= cell_value_reg;
			end else if (sfr_addr == `NVAC_ADDR_PTR_LO) begin
				sfr_rdata <= pointer_low_byte;
			end else if (sfr_addr == `NVAC_ADDR_PTR_HI) begin
				sfr_rdata <= pointer_high_byte;
			end else if (sfr_addr == `NVAC_ADDR_IRQCTL) begin
				sfr_rdata <= {5'h00, nv_done_flag, nv_done_irq_enable, global_irq_enable};
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

endmodule // nvac_ctrl

// >>> nvac_defines.vh
/*
 Constants for the data EEPROM access controller: SFR addresses, bit
 positions, reset values and timing counts. Assumes a single 200 MHz clock.
*/
// How it works
// - Control bit 3 is program_permit; while zero no write cycle starts.
// - Writing one to bit 2 starts a write; hardware clears it when done.
// - program_cycle_go is ignored unless program_permit was already one.
// - Control bit 1 is fetch_permit; while zero no read cycle starts.
// - Writing one to bit 0 starts a read; hardware clears it when done.
// - fetch_go is ignored unless fetch_permit was already one.
// - Control bits 7 to 4 hold nothing and read zero.
// - Power-on reset clears program_permit.
// - A read loads the indexed byte into cell_value_reg; it stays there.
// - A write stores cell_value_reg at the cell_index_reg location.
// - Write length comes from an asynchronous slow timer, not the clock.
// - Write end sets nv_done_flag; request only if its enable is set.
// - Both enables and stack not full give a request; service clears flag.
// - pointer_high_byte resets to zero, sector 0, hiding the control register.
// - The array holds 32 bytes of 8 bits, with a 5-bit index.
// - Control register decodes only at 40H of sector 1, through the port.
`ifndef NVAC_DEFINES_VH
`define NVAC_DEFINES_VH

`define NVAC_ADDR_IAP 8'h02
`define NVAC_ADDR_PTR_LO 8'h03
`define NVAC_ADDR_PTR_HI 8'h04
`define NVAC_ADDR_INDEX 8'h0c
`define NVAC_ADDR_VALUE 8'h0d
`define NVAC_ADDR_IRQCTL 8'h0e

`define NVAC_CTRL_LOW 8'h40
`define NVAC_CTRL_SECTOR 8'h01

`define NVAC_BIT_FETCH_GO 0
`define NVAC_BIT_FETCH_PERMIT 1
`define NVAC_BIT_PROG_GO 2
`define NVAC_BIT_PROG_PERMIT 3

`define NVAC_BIT_GIE 0
`define NVAC_BIT_DONE_EN 1
`define NVAC_BIT_DONE_FLAG 2

`define NVAC_RESET_BYTE 8'h00
`define NVAC_READ_CYCLES 2'h2
`define NVAC_WRITE_SLOW_EDGES 8'h20

`endif

// >>> nvac_tb.sv
/* Bench for nvac_ctrl over its SFR port.
   Assumes a free-running slow clock unrelated to clk. */
`include "nvac_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	reg clk = 0, rst = 1, slow_clk = 0, sfr_wr = 0, sfr_rd = 0;
	reg low_power_req = 0, stack_full = 0, irq_ack = 0;
	reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
	wire [7:0] sfr_rdata;
	wire irq_request, nv_busy;
	int mismatches = 0, total_checks = 0, n;
	always #2.5 clk = ~clk;
	always #17.3 slow_clk = ~slow_clk;
	// Short write timer keeps the run brief
	nvac_ctrl #(.WRITE_SLOW_EDGES(8'h02)) nvac_ctrl_i (.clk(clk), .rst(rst),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_rdata(sfr_rdata), .slow_clk(slow_clk), .low_power_req(low_power_req),
		.stack_full(stack_full), .irq_ack(irq_ack), .irq_request(irq_request),
		.nv_busy(nv_busy));
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] v);
		total_checks++;
		if (v !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge clk);
		sfr_wr = 0;
	endtask
	task rd(input [7:0] a, input [7:0] e, input string s);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1;
		@(negedge clk);
		sfr_rd = 0;
		chk(s, e, sfr_rdata);
	endtask
	// Bounded wait; a hang ends the run
	task idle;
		n = 0;
		while (nv_busy !== 1'b0 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n >= 400) begin
			mismatches++;
			summarize;
		end
	endtask
	task busy_is(input logic b);
		chk("busy", {7'h00, b}, {7'h00, nv_busy});
	endtask
	// Slow clock runs from time zero, so it is settled before any write
	task nv_write(input [7:0] a, input [7:0] d, input [7:0] ie);
		wr(`NVAC_ADDR_IRQCTL, ie & 8'hfe);
		wr(`NVAC_ADDR_INDEX, a);
		wr(`NVAC_ADDR_VALUE, d);
		wr(`NVAC_ADDR_IAP, 8'h08);
		wr(`NVAC_ADDR_IAP, 8'h0c);
		busy_is(1);
		wr(`NVAC_ADDR_IRQCTL, ie);
		idle;
	endtask
	task nv_read(input [7:0] a, input [7:0] e);
		wr(`NVAC_ADDR_INDEX, a);
		wr(`NVAC_ADDR_IAP, 8'hf2);
		wr(`NVAC_ADDR_IAP, 8'hf3);
		idle;
		chk("read_len", {6'h00, `NVAC_READ_CYCLES}, n[7:0]);
		rd(`NVAC_ADDR_IAP, 8'h02, "ctrl");
		rd(`NVAC_ADDR_VALUE, e, "value");
	endtask
	task t_protect;
		wr(`NVAC_ADDR_IAP, 8'h08);
		wr(`NVAC_ADDR_IAP, 8'h0c);
		busy_is(0);
		wr(`NVAC_ADDR_PTR_LO, 8'h40);
		wr(`NVAC_ADDR_PTR_HI, 8'h01);
		rd(`NVAC_ADDR_IAP, 8'h00, "ctrl");
		rd(8'hff, 8'h00, "unmapped");
	endtask
	task t_refuse;
		logic [7:0] tbl [4];
		tbl = '{8'h04, 8'h0c, 8'h01, 8'h03};
		// Each write replaces the byte, so every go meets a permit still zero
		foreach (tbl[i]) begin
			wr(`NVAC_ADDR_IAP, tbl[i]);
			busy_is(0);
		end
		rd(`NVAC_ADDR_IAP, 8'h02, "ctrl");
	endtask
	task t_store;
		nv_write(8'h1f, 8'ha5, 8'h00);
		nv_write(8'h00, 8'h5a, 8'h00);
		rd(`NVAC_ADDR_IAP, 8'h08, "ctrl");
		wr(`NVAC_ADDR_VALUE, 8'h00);
		nv_read(8'h1f, 8'ha5);
		nv_read(8'h00, 8'h5a);
	endtask
	task t_irq;
		stack_full = 1;
		nv_write(8'h03, 8'h11, 8'h03);
		repeat (3) @(negedge clk);
		chk("irq", 8'h00, {7'h00, irq_request});
		rd(`NVAC_ADDR_IRQCTL, 8'h07, "flag");
		stack_full = 0;
		repeat (3) @(negedge clk);
		chk("irq", 8'h01, {7'h00, irq_request});
		irq_ack = 1;
		@(negedge clk);
		irq_ack = 0;
		repeat (2) @(negedge clk);
		chk("irq", 8'h00, {7'h00, irq_request});
		rd(`NVAC_ADDR_IRQCTL, 8'h03, "flag");
	endtask
	task t_abort;
		wr(`NVAC_ADDR_IAP, 8'h08);
		wr(`NVAC_ADDR_IAP, 8'h0c);
		low_power_req = 1;
		@(negedge clk);
		low_power_req = 0;
		@(negedge clk);
		busy_is(0);
		repeat (4) @(negedge clk);
		rd(`NVAC_ADDR_IRQCTL, 8'h03, "flag");
		rd(`NVAC_ADDR_IAP, 8'h08, "ctrl");
		wr(`NVAC_ADDR_VALUE, 8'h77);
		wr(`NVAC_ADDR_IAP, 8'h02);
		wr(`NVAC_ADDR_IAP, 8'h03);
		low_power_req = 1;
		@(negedge clk);
		low_power_req = 0;
		@(negedge clk);
		busy_is(0);
		rd(`NVAC_ADDR_IAP, 8'h02, "ctrl");
		rd(`NVAC_ADDR_VALUE, 8'h77, "value");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		t_protect;
		t_refuse;
		t_store;
		t_irq;
		t_abort;
		summarize;
	end
endmodule // tb
